// *** core/nvsms_defs.vh ***
// constants for the nonvolatile sram host-side mode sequencer
`ifndef NVSMS_DEFS_VH
`define NVSMS_DEFS_VH

// command sequence addresses, low 16 bits only
`define NVSMS_SEQ0          16'h4E38
`define NVSMS_SEQ1          16'hB1C7
`define NVSMS_SEQ2          16'h83E0
`define NVSMS_SEQ3          16'h7C1F
`define NVSMS_SEQ4          16'h703F
`define NVSMS_LAST_SAVE     16'h8FC0
`define NVSMS_LAST_RELOAD   16'h4C63
`define NVSMS_LAST_AS_OFF   16'h8B45
`define NVSMS_LAST_AS_ON    16'h4B46

// command codes on the host command port
`define NVSMS_CMD_READ      3'h0
`define NVSMS_CMD_WRITE     3'h1
`define NVSMS_CMD_SAVE      3'h2
`define NVSMS_CMD_RELOAD    3'h3
`define NVSMS_CMD_AS_OFF    3'h4
`define NVSMS_CMD_AS_ON     3'h5

// timing
`define NVSMS_CLK_MHZ       200
`define NVSMS_T_SETUP_NS    10
`define NVSMS_T_STROBE_NS   30
`define NVSMS_T_RECOV_NS    10
`define NVSMS_T_RELOAD_US   20
`define NVSMS_T_SAVE_MS     10
`define NVSMS_T_POWERUP_MS  5
`define NVSMS_CYC_SETUP     ((`NVSMS_T_SETUP_NS * `NVSMS_CLK_MHZ + 999) / 1000)
`define NVSMS_CYC_STROBE    ((`NVSMS_T_STROBE_NS * `NVSMS_CLK_MHZ + 999) / 1000)
`define NVSMS_CYC_RECOV     ((`NVSMS_T_RECOV_NS * `NVSMS_CLK_MHZ + 999) / 1000)
`define NVSMS_CYC_RELOAD    (`NVSMS_T_RELOAD_US * `NVSMS_CLK_MHZ)
`define NVSMS_CYC_SAVE      (`NVSMS_T_SAVE_MS * 1000 * `NVSMS_CLK_MHZ)
`define NVSMS_CYC_POWERUP   (`NVSMS_T_POWERUP_MS * 1000 * `NVSMS_CLK_MHZ)

`endif

// *** core/nvsms_host.v ***
// host controller driving a nonvolatile sram through its parallel pins
// Summary of operation
// - host holds data_in_strob_n high throughout every read cycle.
// - write ends on first rising edge of data_in_strob_n or chip_on_n.
// - host accepts a command, writes included, only while hard_store_busy_n is high.
// - command is six reads in exact order starting 4E38, B1C7, fifth 703F.
// - strobe stays high over all six reads, else no nonvolatile cycle.
// - each sequence step may be clocked by chip_on_n or out_drv_n.
`timescale 1ns/1ps
`default_nettype none
`include "nvsms_defs.vh"
module nvsms_host
#(
	parameter SAVE_CYCLES    = `NVSMS_CYC_SAVE,
	parameter POWERUP_CYCLES = `NVSMS_CYC_POWERUP,
	parameter RELOAD_CYCLES  = `NVSMS_CYC_RELOAD
)
(
	// clock and reset
	input  wire        clock,
	input  wire        nrst,
	// host command port
	input  wire        cmd_valid,
	output wire        cmd_ready,
	input  wire [2:0]  cmd_op,
	input  wire [16:0] cmd_addr,
	input  wire [7:0]  cmd_wdata,
	input  wire        cmd_by_oe,
	output reg         rsp_valid,
	output reg  [7:0]  rsp_rdata,
	output reg         dev_ready,
	output reg         wrote_since_nv,
	// device pins
	output reg  [16:0] mem_addr,
	output reg         chip_on_n,
	output reg         data_in_strob_n,
	output reg         out_drv_n,
	input  wire [7:0]  dq_in,
	output reg  [7:0]  dq_out,
	output reg         dq_oe,
	input  wire        hard_store_busy_n_in,
	output wire        hard_store_busy_n_out,
	output wire        hard_store_busy_n_oe
);

	localparam [31:0] C_SETUP  = `NVSMS_CYC_SETUP;
	localparam [31:0] C_STROBE = `NVSMS_CYC_STROBE;
	localparam [31:0] C_RECOV  = `NVSMS_CYC_RECOV;

	localparam [6:0] S_PWRUP  = 7'h01;
	localparam [6:0] S_IDLE   = 7'h02;
	localparam [6:0] S_SETUP  = 7'h04;
	localparam [6:0] S_STROBE = 7'h08;
	localparam [6:0] S_RECOV  = 7'h10;
	localparam [6:0] S_WAIT   = 7'h20;
	localparam [6:0] S_NEXT   = 7'h40;

	reg        rst_m;
	reg        rst_q;
	reg [6:0]  state;
	reg [31:0] cnt;
	reg [2:0]  op;
	reg [2:0]  step;
	reg [16:0] base_addr;
	reg [7:0]  wdata;
	reg        by_oe;
	reg [31:0] wait_len;

	// the host never requests a hardware save; pin is only watched
	assign hard_store_busy_n_out = 1'b1;
	assign hard_store_busy_n_oe  = 1'b0;
	assign cmd_ready = (state == S_IDLE) && hard_store_busy_n_in;

	always @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_m <= 1'b0;
			rst_q <= 1'b0;
		end
		else
		begin
			rst_m <= 1'b1;
			rst_q <= rst_m;
		end
	end

	wire is_seq = (op != `NVSMS_CMD_READ) && (op != `NVSMS_CMD_WRITE);
	wire is_wr  = (op == `NVSMS_CMD_WRITE);
	// sixth address of each command
	reg [15:0] last_addr;
	always @*
	begin
		case (op)
			`NVSMS_CMD_SAVE:   last_addr = `NVSMS_LAST_SAVE;
			`NVSMS_CMD_RELOAD: last_addr = `NVSMS_LAST_RELOAD;
			`NVSMS_CMD_AS_OFF: last_addr = `NVSMS_LAST_AS_OFF;
			default:           last_addr = `NVSMS_LAST_AS_ON;
		endcase
	end

	// address for the current step; top bit kept from caller, ignored by device
	reg [15:0] seq_addr;
	always @*
	begin
		case (step)
			3'h0:    seq_addr = `NVSMS_SEQ0;
			3'h1:    seq_addr = `NVSMS_SEQ1;
			3'h2:    seq_addr = `NVSMS_SEQ2;
			3'h3:    seq_addr = `NVSMS_SEQ3;
			3'h4:    seq_addr = `NVSMS_SEQ4;
			default: seq_addr = last_addr;
		endcase
	end
	wire [16:0] step_addr = is_seq ? {base_addr[16], seq_addr} : base_addr;
	// wait after the command finishes, in cycles
	reg [31:0] after_len;
	always @*
	begin
		case (op)
			`NVSMS_CMD_SAVE:   after_len = SAVE_CYCLES;
			`NVSMS_CMD_RELOAD: after_len = RELOAD_CYCLES;
			default:           after_len = 32'h00000000;
		endcase
	end

	always @(posedge clock or negedge rst_q)
	begin
		if (!rst_q)
		begin
			state           <= S_PWRUP;
			cnt             <= 32'h00000000;
			op              <= 3'h0;
			step            <= 3'h0;
			base_addr       <= 17'h00000;
			wdata           <= 8'h00;
			by_oe           <= 1'b0;
			wait_len        <= 32'h00000000;
			mem_addr        <= 17'h00000;
			chip_on_n       <= 1'b1;
			data_in_strob_n <= 1'b1;
			out_drv_n       <= 1'b1;
			dq_out          <= 8'h00;
			dq_oe           <= 1'b0;
			rsp_valid       <= 1'b0;
			rsp_rdata       <= 8'h00;
			dev_ready       <= 1'b0;
			wrote_since_nv  <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			case (state)
				S_PWRUP:
				begin
					// supply is taken as crossing the fail level at reset release
					if (cnt + 32'h1 >= POWERUP_CYCLES)
					begin
						state     <= S_IDLE;
						cnt       <= 32'h00000000;
						dev_ready <= 1'b1;
					end
					else
						cnt <= cnt + 32'h1;
				end
				S_IDLE:
				begin
					if (cmd_valid && cmd_ready)
					begin
						op        <= cmd_op;
						base_addr <= cmd_addr;
						wdata     <= cmd_wdata;
						by_oe     <= cmd_by_oe;
						step      <= 3'h0;
						cnt       <= 32'h00000000;
						state     <= S_SETUP;
					end
				end
				S_SETUP:
				begin
					// address moves only while both strobes are high
					mem_addr <= step_addr;
					dq_out   <= wdata;
					dq_oe    <= is_wr;
					if (cnt + 32'h1 >= C_SETUP)
					begin
						cnt   <= 32'h00000000;
						state <= S_STROBE;
						if (is_wr)
						begin
							// strobe falls with chip_on_n and out_drv_n stays high, so device never turns its drivers on
							data_in_strob_n <= 1'b0;
							chip_on_n       <= 1'b0;
						end
						else if (is_seq && by_oe)
						begin
							chip_on_n <= 1'b0;
						end
						else
						begin
							chip_on_n <= 1'b0;
							out_drv_n <= 1'b0;
						end
					end
					else
						cnt <= cnt + 32'h1;
				end
				S_STROBE:
				begin
					// for an output-clocked step, out_drv_n falls one cycle after chip_on_n
					if (is_seq && by_oe && out_drv_n)
						out_drv_n <= 1'b0;
					else if (cnt + 32'h1 >= C_STROBE)
					begin
						cnt <= 32'h00000000;
						if (!is_wr)
							rsp_rdata <= dq_in;
						if (is_wr)
						begin
							// both rise together; the device latches on the first
							data_in_strob_n <= 1'b1;
							chip_on_n       <= 1'b1;
							wrote_since_nv  <= 1'b1;
						end
						else if (is_seq && by_oe)
							out_drv_n <= 1'b1;
						else
						begin
							chip_on_n <= 1'b1;
							out_drv_n <= 1'b1;
						end
						state <= S_RECOV;
					end
					else
						cnt <= cnt + 32'h1;
				end
				S_RECOV:
				begin
					chip_on_n <= 1'b1;
					out_drv_n <= 1'b1;
					dq_oe     <= 1'b0;
					if (cnt + 32'h1 >= C_RECOV)
					begin
						cnt <= 32'h00000000;
						if (is_seq && step != 3'h5)
						begin
							step  <= step + 3'h1;
							state <= S_SETUP;
						end
						else
						begin
							wait_len <= after_len;
							state    <= S_WAIT;
						end
					end
					else
						cnt <= cnt + 32'h1;
				end
				S_WAIT:
				begin
					if (cnt >= wait_len)
					begin
						cnt   <= 32'h00000000;
						state <= S_NEXT;
					end
					else
						cnt <= cnt + 32'h1;
				end
				S_NEXT:
				begin
					// every command also waits for the busy pin to release
					if (hard_store_busy_n_in)
					begin
						if (op == `NVSMS_CMD_SAVE || op == `NVSMS_CMD_RELOAD)
							wrote_since_nv <= 1'b0;
						rsp_valid <= 1'b1;
						state     <= S_IDLE;
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** tb/nvsms_host_assertions.sv ***
// pin assertions for the host controller
`timescale 1ns/1ps
`default_nettype none
module nvsms_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	// device pins
	input wire logic [16:0] mem_addr,
	input wire logic        chip_on_n,
	input wire logic        data_in_strob_n,
	input wire logic        out_drv_n,
	input wire logic        dq_oe,
	input wire logic        hard_store_busy_n_in
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	a_read_strobe: assert property (!chip_on_n && !out_drv_n |-> data_in_strob_n)
		else $error("read with write low");
	a_busy_write: assert property ($fell(data_in_strob_n) |-> hard_store_busy_n_in)
		else $error("write while busy");
	a_addr_held: assert property ($changed(mem_addr) |-> chip_on_n || data_in_strob_n)
		else $error("address moved in write");
	a_write_end: assert property ($rose(data_in_strob_n) |-> $rose(chip_on_n) && dq_oe)
		else $error("bad write end");
	a_step_width: assert property ($fell(chip_on_n | out_drv_n) |-> !chip_on_n [*5])
		else $error("read step short");
	a_read_free: assert property (!out_drv_n |-> !dq_oe)
		else $error("bus driven in read");
	a_write_drive: assert property (!data_in_strob_n |-> out_drv_n && dq_oe)
		else $error("bad write drive");
endmodule
bind nvsms_host nvsms_chk u_chk (.clock, .nrst, .mem_addr, .chip_on_n, .data_in_strob_n,
	.out_drv_n, .dq_oe, .hard_store_busy_n_in);
`default_nettype wire

// *** tb/nvsms_dev_model.sv ***
// pin-level model of the nonvolatile sram
`timescale 1ns/1ps
`default_nettype none
module nvsms_dev (
	// pins
	input wire logic [16:0] mem_addr,
	input wire logic        chip_on_n,
	input wire logic        data_in_strob_n,
	input wire logic        out_drv_n,
	input wire logic [7:0]  dq_in,
	output wire logic [7:0] dev_q,
	output logic            busy_n,
	// mode state
	output logic            auto_en
);
	logic [7:0]  mem [16];
	logic [7:0]  nv [16];
	logic [15:0] seq [9] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F,
		16'h8FC0, 16'h4C63, 16'h8B45, 16'h4B46};
	logic [2:0]  pos = 3'h0;
	wire [15:0]  a = mem_addr[15:0];
	wire         rd = !chip_on_n && !out_drv_n && data_in_strob_n;
	wire         wr = !chip_on_n && !data_in_strob_n;
	wire         hz = pos == 3'h5 && (a == seq[5] || a == seq[6]);
	// undriven bus reads back inverted so a stray sample shows
	assign dev_q = rd && !hz ? mem[a[3:0]] : ~mem[a[3:0]];
	initial busy_n = 1'b1;
	initial auto_en = 1'b1;
	always @(negedge wr)
	begin
		mem[a[3:0]] = dq_in;
		pos = 3'h0;
	end
	always @(negedge rd)
		if (pos < 3'h5)
			pos = a === seq[pos] ? pos + 3'h1 : {2'h0, a === seq[0]};
		else
		begin
			pos = 3'h0;
			auto_en = a == seq[7] ? 1'b0 : a == seq[8] ? 1'b1 : auto_en;
			if (a == seq[6])
				#50 mem = nv;
			if (a == seq[5])
			begin
				busy_n = 1'b0;
				#400 nv = mem;
				busy_n = 1'b1;
			end
		end
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the host controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic        cmd_valid = 1'b0;
	logic        cmd_by_oe = 1'b0;
	logic [2:0]  cmd_op = 3'h0;
	logic [16:0] cmd_addr = 17'h00000;
	logic [7:0]  cmd_wdata = 8'h00;
	wire         cmd_ready, rsp_valid, dev_ready, wrote_since_nv;
	wire         chip_on_n, data_in_strob_n, out_drv_n, dq_oe;
	wire         hard_store_busy_n_in, hb_out, hb_oe, busy_n, auto_en;
	wire [7:0]   rsp_rdata, dq_out, dev_q, dq_in;
	wire [16:0]  mem_addr;
	int          n_fail = 0;
	int          total_checks = 0;
	assign dq_in = dq_oe ? dq_out : dev_q;
	// busy line is open drain with a pull-up
	assign hard_store_busy_n_in = busy_n & (hb_oe ? hb_out : 1'b1);
	always #2.5 clock = ~clock;
	nvsms_host #(.SAVE_CYCLES(20), .POWERUP_CYCLES(20), .RELOAD_CYCLES(20)) dut (
		.clock, .nrst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_by_oe,
		.rsp_valid, .rsp_rdata, .dev_ready, .wrote_since_nv, .mem_addr, .chip_on_n,
		.data_in_strob_n, .out_drv_n, .dq_in, .dq_out, .dq_oe, .hard_store_busy_n_in,
		.hard_store_busy_n_out(hb_out), .hard_store_busy_n_oe(hb_oe));
	nvsms_dev u_dev (.mem_addr, .chip_on_n, .data_in_strob_n, .out_drv_n, .dq_in, .dev_q,
		.busy_n, .auto_en);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("%0d checks, %0d mismatches", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cmd(input logic [2:0] op, input logic [16:0] ad,
		input logic [7:0] wd = 8'h00, input logic oe = 1'b0);
		@(negedge clock);
		cmd_op = op;
		cmd_addr = ad;
		cmd_wdata = wd;
		cmd_by_oe = oe;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			@(negedge clock);
		@(negedge clock);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1)
			@(negedge clock);
	endtask
	task automatic t_powerup();
		repeat (10) @(negedge clock);
		chk(cmd_ready, 8'h00);
		repeat (20) @(negedge clock);
		chk(dev_ready, 8'h01);
	endtask
	task automatic t_rw();
		cmd(3'h1, 17'h00003, 8'h5A);
		cmd(3'h1, 17'h1000C, 8'hC3);
		cmd(3'h0, 17'h00003);
		chk(rsp_rdata, 8'h5A);
		cmd(3'h0, 17'h1000C);
		chk(rsp_rdata, 8'hC3);
		chk(wrote_since_nv, 8'h01);
		chk(hb_oe, 8'h00);
	endtask
	task automatic t_nv();
		cmd(3'h2, 17'h10000);
		chk(wrote_since_nv, 8'h00);
		cmd(3'h1, 17'h00003, 8'h00);
		cmd(3'h3, 17'h00000, 8'h00, 1'b1);
		chk(wrote_since_nv, 8'h00);
		cmd(3'h0, 17'h00003);
		chk(rsp_rdata, 8'h5A);
	endtask
	task automatic t_auto();
		cmd(3'h4, 17'h00000, 8'h00, 1'b1);
		chk(auto_en, 8'h00);
		cmd(3'h5, 17'h10000);
		chk(auto_en, 8'h01);
	endtask
	// the whole run needs well under this many cycles
	initial
	begin
		repeat (5000) @(posedge clock);
		n_fail++;
		complete_run();
	end
	initial
	begin
		repeat (3) @(negedge clock);
		nrst = 1'b1;
		t_powerup();
		t_rw();
		t_nv();
		t_auto();
		complete_run();
	end
endmodule
`default_nettype wire
